// >>> core/pif_cfg.svh
// Constants of the peripheral interrupt flag block: offsets, masks, answers.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH

// Register indices; the byte address is four times the index
`define PIF_THREE_IDX 12'h08F
`define PIF_FOUR_IDX 12'h090

// Writable, hardware-set bits of each register
`define PIF_THREE_WMASK 8'hC3
`define PIF_FOUR_WMASK 8'h3F
`define PIF_FLAGS_RESET 8'h00

// Bit positions inside flags three
`define PIF_B_S1_COLL 7
`define PIF_B_S1_EVT 6
`define PIF_B_U2_RX 5
`define PIF_B_U2_TX 4
`define PIF_B_U1_RX 3
`define PIF_B_U1_TX 2
`define PIF_B_LC4 1
`define PIF_B_LC3 0

// Bit positions inside flags four
`define PIF_B_ZC 5
`define PIF_B_ADT 4
`define PIF_B_ADC 3
`define PIF_B_CMP1 2
`define PIF_B_S2_COLL 1
`define PIF_B_S2_EVT 0

// Bus answers
`define PIF_RESP_OKAY 2'h0
`define PIF_RESP_SLVERR 2'h2

`endif

// >>> core/pif_pkg.sv
// Types shared by the peripheral interrupt flag block.
// Assumes the peripherals deliver events and buffer levels on aclk.
package pif_pkg;

    // One-cycle event pulses from the peripherals
    typedef struct packed {
        logic serial_one_collision;
        logic serial_one_event;
        logic logic_cell_four;
        logic logic_cell_three;
        logic zero_cross;
        logic adc_threshold;
        logic adc_conversion;
        logic comparator_one;
        logic serial_two_collision;
        logic serial_two_event;
    } pif_events_t;

    // Buffer levels from the two uarts
    typedef struct packed {
        logic uart_two_rx_nonempty;
        logic uart_two_tx_empty;
        logic uart_one_rx_nonempty;
        logic uart_one_tx_empty;
    } pif_uart_status_t;

endpackage

// >>> core/pif_flags.sv
// Peripheral interrupt flag registers three and four behind an AXI4-Lite slave.
// Assumes events and uart levels come from logic on aclk; one write and one
// read under way at a time, as AXI4-Lite masters of this system issue them.
`timescale 1ns/1ps
`include "pif_cfg.svh"

module pif_flags
    import pif_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // Write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address channel
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // Read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Peripheral side
    input wire pif_events_t events,
    input wire pif_uart_status_t uart_status,
    // Flag values towards enable and priority logic
    output logic [7:0] flags_three,
    output logic [7:0] flags_four
);

    // Word decode of a byte address against a register index
    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
        hits = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
    endfunction

    // Sticky flag update: write loads writable bits, hardware set wins
    function automatic logic [7:0] flag_next(
        input logic [7:0] cur,
        input logic [7:0] wmask,
        input logic wr,
        input logic [7:0] wval,
        input logic [7:0] hw_set
    );
        logic [7:0] kept;
        kept = wr ? (wval & wmask) : (cur & wmask);
        flag_next = kept | (hw_set & wmask);
    endfunction

    // Write channel state
    logic aw_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    // Read channel state
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Flag state
    logic [7:0] three_reg;
    logic [7:0] four_reg;
    logic [7:0] three_next;
    logic [7:0] four_next;

    // Handshakes and write commit
    wire aw_take = awvalid & awready_reg;
    wire w_take = wvalid & wready_reg;
    wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire ar_take = arvalid & arready_reg;

    // Write path next values
    wire aw_held_next = (aw_held_reg | aw_take) & ~wr_fire;
    wire w_held_next = (w_held_reg | w_take) & ~wr_fire;
    wire bvalid_next = wr_fire | (bvalid_reg & ~bready);
    wire awready_next = ~aw_held_next & ~bvalid_next;
    wire wready_next = ~w_held_next & ~bvalid_next;

    // Write target decode; only the low byte lane carries a register
    wire wr_sel_three = hits(aw_addr_reg, `PIF_THREE_IDX);
    wire wr_sel_four = hits(aw_addr_reg, `PIF_FOUR_IDX);
    wire wr_mapped = wr_sel_three | wr_sel_four;
    wire wr_three = wr_fire & wr_sel_three & w_strb_reg[0];
    wire wr_four = wr_fire & wr_sel_four & w_strb_reg[0];
    wire [1:0] bresp_next = wr_mapped ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;

    // Read path next values
    wire rvalid_next = ar_take | (rvalid_reg & ~rready);
    wire arready_next = ~rvalid_next;
    wire rd_sel_three = hits(araddr, `PIF_THREE_IDX);
    wire rd_sel_four = hits(araddr, `PIF_FOUR_IDX);
    wire [7:0] rd_byte = rd_sel_three ? three_reg : (rd_sel_four ? four_reg : 8'h00);
    wire [31:0] rd_word = {24'h00_0000, rd_byte};
    wire [1:0] rresp_next = (rd_sel_three | rd_sel_four) ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;

    // Hardware sets of flags three, no enable gates them
    wire [7:0] three_set = {events.serial_one_collision,
                            events.serial_one_event,
                            4'h0,
                            events.logic_cell_four,
                            events.logic_cell_three};

    // Uart buffer levels mirrored into bits 5 to 2, writes ignored
    wire [7:0] three_level = {2'h0,
                              uart_status.uart_two_rx_nonempty,
                              uart_status.uart_two_tx_empty,
                              uart_status.uart_one_rx_nonempty,
                              uart_status.uart_one_tx_empty,
                              2'h0};

    // Hardware sets of flags four, bits 7 and 6 absent
    wire [7:0] four_set = {2'h0,
                           events.zero_cross,
                           events.adc_threshold,
                           events.adc_conversion,
                           events.comparator_one,
                           events.serial_two_collision,
                           events.serial_two_event};

    // Next flag values, set wins over a coinciding clear
    assign three_next = flag_next(three_reg, `PIF_THREE_WMASK, wr_three, w_data_reg[7:0],
                                  three_set) | three_level;
    assign four_next = flag_next(four_reg, `PIF_FOUR_WMASK, wr_four, w_data_reg[7:0],
                                 four_set);

    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            if (aw_take) begin
                aw_addr_reg <= awaddr;
            end
            if (w_take) begin
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
        end
    end

    // Write response and channel readiness
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `PIF_RESP_OKAY;
        end else begin
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            if (wr_fire) begin
                bresp_reg <= bresp_next;
            end
        end
    end

    // Read answer, no side effect on any flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `PIF_RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_word;
                rresp_reg <= rresp_next;
            end
        end
    end

    // Flag registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            three_reg <= `PIF_FLAGS_RESET;
            four_reg <= `PIF_FLAGS_RESET;
        end else begin
            three_reg <= three_next;
            four_reg <= four_next;
        end
    end

    // Outputs straight from flip-flops
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign flags_three = three_reg;
    assign flags_four = four_reg;

    // Checks on the flag behaviour and bus answers
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Collision on serial one sets bit 7 on the next edge
    property p_s1_coll_set;
        events.serial_one_collision |=> three_reg[`PIF_B_S1_COLL];
    endproperty
    a_s1_coll_set: assert property (p_s1_coll_set)
        else $error("serial one collision flag not set");

    // Bit 7 holds while no write reaches flags three
    property p_s1_coll_hold;
        three_reg[`PIF_B_S1_COLL] && !wr_three |=> three_reg[`PIF_B_S1_COLL];
    endproperty
    a_s1_coll_hold: assert property (p_s1_coll_hold)
        else $error("serial one collision flag dropped without a write");

    // Serial one event sets bit 6
    property p_s1_evt_set;
        events.serial_one_event |=> three_reg[`PIF_B_S1_EVT];
    endproperty
    a_s1_evt_set: assert property (p_s1_evt_set)
        else $error("serial one event flag not set");

    // Uart receive and transmit flags track the buffer levels one cycle later
    property p_uart_mirror;
        ##1 three_reg[5:2] == $past({uart_status.uart_two_rx_nonempty,
                                    uart_status.uart_two_tx_empty,
                                    uart_status.uart_one_rx_nonempty,
                                    uart_status.uart_one_tx_empty});
    endproperty
    a_uart_mirror: assert property (p_uart_mirror)
        else $error("uart flags do not follow buffer levels");

    // A write never moves the read-only uart bits
    property p_uart_ro;
        wr_three && (uart_status == $past(uart_status)) |=> $stable(three_reg[5:2]);
    endproperty
    a_uart_ro: assert property (p_uart_ro)
        else $error("write altered a read-only uart flag");

    // Logic cell events set bits 1 and 0
    property p_cells_set;
        events.logic_cell_four || events.logic_cell_three
            |=> (three_reg[1:0] & $past({events.logic_cell_four, events.logic_cell_three}))
                == $past({events.logic_cell_four, events.logic_cell_three});
    endproperty
    a_cells_set: assert property (p_cells_set)
        else $error("logic cell flags not set");

    // Flags four upper bits always read zero
    property p_four_top;
        four_reg[7:6] == 2'h0;
    endproperty
    a_four_top: assert property (p_four_top)
        else $error("unimplemented bits of flags four are set");

    // Each flags four event sets its own bit
    property p_four_set;
        |four_set[5:0] |=> ((four_reg & $past(four_set)) == $past(four_set));
    endproperty
    a_four_set: assert property (p_four_set)
        else $error("flags four event not latched");

    // Zero written clears a flag when no event coincides
    property p_four_clear;
        wr_four && w_data_reg[`PIF_B_ADC] == 1'b0 && !events.adc_conversion
            |=> !four_reg[`PIF_B_ADC];
    endproperty
    a_four_clear: assert property (p_four_clear)
        else $error("write of zero failed to clear adc flag");

    // A coinciding event beats the clear
    property p_set_wins;
        wr_four && w_data_reg[`PIF_B_S2_COLL] == 1'b0 && events.serial_two_collision
            |=> four_reg[`PIF_B_S2_COLL];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear won over a coinciding set");

    // Write response follows the commit on the next edge with the decoded answer
    property p_bresp;
        wr_fire |=> bvalid_reg && bresp_reg == $past(bresp_next);
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response not raised after commit");

    // Write response stands until bready accepts it
    property p_bresp_hold;
        bvalid_reg && !bready |=> bvalid_reg && $stable(bresp_reg);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped before acceptance");

    // Read answer comes on the edge after the address is taken
    property p_rvalid;
        ar_take |=> rvalid_reg && rdata_reg[31:8] == 24'h00_0000;
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read answer late or upper bits not zero");

    // Read answer stands until rready accepts it
    property p_rdata_hold;
        rvalid_reg && !rready |=> rvalid_reg && $stable(rdata_reg) && $stable(rresp_reg);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read answer changed before acceptance");

    // Flags four bits stay set while no write reaches the register
    property p_four_hold;
        !wr_four |=> (four_reg & $past(four_reg)) == $past(four_reg);
    endproperty
    a_four_hold: assert property (p_four_hold)
        else $error("flags four bit dropped without a write");

    // Main scenarios
    c_set_wins: cover property (wr_four && !w_data_reg[`PIF_B_S2_COLL] && events.serial_two_collision);
    c_read_three: cover property (ar_take && rd_sel_three ##1 rvalid_reg);
    c_unmapped_write: cover property (wr_fire && !wr_mapped);
    c_uart_rx_clear: cover property ($fell(three_reg[`PIF_B_U1_RX]));

endmodule

// >>> verification/peripheral_irq_flags_3_4_tb.sv
// Self-checking bench for the peripheral interrupt flag registers three and four.
// Assumes pif_flags with its AXI4-Lite slave, one clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "pif_cfg.svh"

module peripheral_irq_flags_3_4_tb import pif_pkg::*;;
    typedef struct packed {
        logic [9:0] ev;
        logic [3:0] us;
        logic [7:0] e3;
        logic [7:0] e4;
    } pif_tb_row_t;

    localparam logic [15:0] A_THREE = 16'(`PIF_THREE_IDX * 4);
    localparam logic [15:0] A_FOUR = 16'(`PIF_FOUR_IDX * 4);
    localparam int LIMIT = 40;

    // Bus master side
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic [2:0] awprot = '0;
    logic [2:0] arprot = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    // Peripheral side
    pif_events_t events = '0;
    pif_uart_status_t uart_status = '0;
    logic [7:0] flags_three, flags_four;
    // Bookkeeping
    int n_errors = 0;
    int samples_checked = 0;
    logic [1:0] resp;
    logic [31:0] rd;
    pif_tb_row_t rows [10];

    // Free-running clock, 10 ns period
    always #5 aclk = ~aclk;

    pif_flags #(.ADDR_W(16)) DUT (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .events(events), .uart_status(uart_status),
        .flags_three(flags_three), .flags_four(flags_four)
    );

    // Verdict and end of run
    task automatic print_verdict();
        $display("samples checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_data(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic timed_out(input string name);
        n_errors++;
        $display("unexpected %s: expected an answer, seen none", name);
        print_verdict();
    endtask

    // One write: address and data offered together, each released when taken
    task automatic axi_write(input logic [15:0] addr, input logic [7:0] data,
                             input logic [3:0] strb, output logic [1:0] got);
        int i;
        @(posedge aclk);
        awaddr <= addr;
        awvalid <= 1'b1;
        wdata <= {24'h00_0000, data};
        wstrb <= strb;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < LIMIT; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        got = bresp;
        bready <= 1'b0;
        if (i == LIMIT) timed_out("write response");
    endtask

    // One read: address held until taken, data taken with rvalid
    task automatic axi_read(input logic [15:0] addr, output logic [31:0] data,
                            output logic [1:0] got);
        int i;
        @(posedge aclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < LIMIT; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        data = rdata;
        got = rresp;
        rready <= 1'b0;
        if (i == LIMIT) timed_out("read data");
    endtask

    // Read a register and compare both the value and the answer code
    task automatic check_reg(input logic [15:0] addr, input logic [7:0] exp, input string name);
        axi_read(addr, rd, resp);
        chk_data(name, {24'h00_0000, exp}, rd);
        chk_resp(name, `PIF_RESP_OKAY, resp);
    endtask

    initial begin
        // One event pulse and one set of buffer levels per row
        rows[0] = '{10'h200, 4'h0, 8'h80, 8'h00};
        rows[1] = '{10'h100, 4'h8, 8'h60, 8'h00};
        rows[2] = '{10'h080, 4'h4, 8'h12, 8'h00};
        rows[3] = '{10'h040, 4'h2, 8'h09, 8'h00};
        rows[4] = '{10'h020, 4'h1, 8'h04, 8'h20};
        rows[5] = '{10'h010, 4'h0, 8'h00, 8'h10};
        rows[6] = '{10'h008, 4'h0, 8'h00, 8'h08};
        rows[7] = '{10'h004, 4'h0, 8'h00, 8'h04};
        rows[8] = '{10'h002, 4'h0, 8'h00, 8'h02};
        rows[9] = '{10'h001, 4'h0, 8'h00, 8'h01};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // Ordinary cases, clearing both registers before each row
        foreach (rows[k]) begin
            axi_write(A_THREE, 8'h00, 4'h1, resp);
            axi_write(A_FOUR, 8'h00, 4'h1, resp);
            @(posedge aclk);
            uart_status <= rows[k].us;
            events <= rows[k].ev;
            @(posedge aclk);
            events <= '0;
            @(posedge aclk);
            #1;
            chk_data("flags_three pins", {24'h00_0000, rows[k].e3}, {24'h00_0000, flags_three});
            chk_data("flags_four pins", {24'h00_0000, rows[k].e4}, {24'h00_0000, flags_four});
            check_reg(A_THREE, rows[k].e3, "flags three");
            check_reg(A_FOUR, rows[k].e4, "flags four");
        end
        // Ones land only in writable bits
        uart_status <= '0;
        axi_write(A_THREE, 8'hFF, 4'h1, resp);
        chk_resp("write answer", `PIF_RESP_OKAY, resp);
        check_reg(A_THREE, 8'hC3, "three all ones");
        axi_write(A_FOUR, 8'hFF, 4'h1, resp);
        check_reg(A_FOUR, 8'h3F, "four all ones");
        // Strobe off leaves the register alone
        axi_write(A_FOUR, 8'h00, 4'h0, resp);
        check_reg(A_FOUR, 8'h3F, "four strobe off");
        // Clearing write leaves the uart levels visible
        uart_status <= 4'hF;
        axi_write(A_THREE, 8'h00, 4'h1, resp);
        check_reg(A_THREE, 8'h3C, "three uart levels");
        // Receive buffers drained, transmit buffers still empty
        uart_status <= 4'h5;
        @(posedge aclk);
        check_reg(A_THREE, 8'h14, "three rx drained");
        // Event at the commit edge of a clearing write wins
        fork
            axi_write(A_FOUR, 8'h00, 4'h1, resp);
            begin
                repeat (2) @(posedge aclk);
                events.adc_conversion <= 1'b1;
                events.serial_two_collision <= 1'b1;
                @(posedge aclk);
                events <= '0;
            end
        join
        check_reg(A_FOUR, 8'h0A, "set beats clear");
        axi_write(A_FOUR, 8'h00, 4'h1, resp);
        check_reg(A_FOUR, 8'h00, "four cleared");
        // Unmapped address is refused and changes nothing
        axi_write(A_FOUR + 16'h0004, 8'hFF, 4'h1, resp);
        chk_resp("unmapped write", `PIF_RESP_SLVERR, resp);
        axi_read(A_FOUR + 16'h0004, rd, resp);
        chk_resp("unmapped read", `PIF_RESP_SLVERR, resp);
        chk_data("unmapped data", 32'h0000_0000, rd);
        check_reg(A_FOUR, 8'h00, "four after unmapped");
        // Reset in mid-run with flags set
        axi_write(A_THREE, 8'hC3, 4'h1, resp);
        axi_write(A_FOUR, 8'h3F, 4'h1, resp);
        uart_status <= '0;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        #1;
        chk_data("flags_three in reset", 32'h0000_0000, {24'h00_0000, flags_three});
        chk_data("flags_four in reset", 32'h0000_0000, {24'h00_0000, flags_four});
        @(posedge aclk);
        aresetn <= 1'b1;
        check_reg(A_THREE, 8'h00, "three after reset");
        check_reg(A_FOUR, 8'h00, "four after reset");
        print_verdict();
    end
endmodule
